// ### rtl/mdc_axis_det.sv
// One axis of motion and stillness comparison with ac references
module mdc_axis_det (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Control side
	mdc_axis_if.det bus
);
	logic signed [15:0] act_ref;
	logic signed [15:0] inact_ref;
	logic arm_pend;
	logic [16:0] act_mag;
	logic [16:0] inact_mag;
	logic [16:0] act_lim;
	logic [16:0] inact_lim;

	function automatic logic [16:0] mdc_abs(input logic signed [16:0] d);
		return d[16] ? 17'(-d) : 17'(d);
	endfunction

	// see R05 R06 R11
	always_comb begin
		act_lim = 17'(bus.act_thr) << mdc_pkg::THRESH_SHIFT;
		inact_lim = 17'(bus.inact_thr) << mdc_pkg::THRESH_SHIFT;
		act_mag = bus.act_ac ? mdc_abs(17'(bus.act_sample) - 17'(act_ref))
			: mdc_abs(17'(bus.act_sample));
		inact_mag = bus.inact_ac
			? mdc_abs(17'(bus.inact_sample) - 17'(inact_ref))
			: mdc_abs(17'(bus.inact_sample));
	end

	// Reference taken at the first sample after detection starts
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			arm_pend <= 1'b0;
			act_ref <= 16'sh0000;
		end else if (bus.sample_stb && (arm_pend || bus.act_arm)) begin
			arm_pend <= 1'b0;
			act_ref <= bus.act_sample; // see R12
		end else if (bus.act_arm) begin
			arm_pend <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus.act_hit <= 1'b0;
		end else if (bus.sample_stb) begin
			// No hit on the sample that becomes the ac reference
			bus.act_hit <= (act_mag > act_lim)
				&& !(bus.act_ac && (arm_pend || bus.act_arm)); // see R12
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bus.inact_below <= 1'b0;
			inact_ref <= 16'sh0000;
		end else if (bus.sample_stb) begin
			bus.inact_below <= inact_mag < inact_lim;
			if (inact_mag >= inact_lim) begin
				inact_ref <= bus.inact_sample; // see R13
			end
		end
	end
endmodule // mdc_axis_det

// ### rtl/mdc_axis_if.sv
// Per-axis link between the control logic and one axis comparator
interface mdc_axis_if;
	logic sample_stb;
	logic act_arm;
	logic signed [15:0] act_sample;
	logic signed [15:0] inact_sample;
	logic [7:0] act_thr;
	logic [7:0] inact_thr;
	logic act_ac;
	logic inact_ac;
	logic act_hit;
	logic inact_below;
	modport ctl (output sample_stb, act_arm, act_sample, inact_sample,
		act_thr, inact_thr, act_ac, inact_ac, input act_hit, inact_below);
	modport det (input sample_stb, act_arm, act_sample, inact_sample,
		act_thr, inact_thr, act_ac, inact_ac, output act_hit, inact_below);
endinterface

// ### rtl/mdc_pkg.sv
// Shared constants for the motion detect configuration block
package mdc_pkg;
	// Register addresses on the serial port
	localparam logic [5:0] ADDR_SERIAL = 6'h04;
	localparam logic [5:0] ADDR_RESET_CMD = 6'h18;
	localparam logic [5:0] ADDR_OFS_X = 6'h1E;
	localparam logic [5:0] ADDR_OFS_Y = 6'h1F;
	localparam logic [5:0] ADDR_OFS_Z = 6'h20;
	localparam logic [5:0] ADDR_MOT_THR = 6'h24;
	localparam logic [5:0] ADDR_STILL_THR = 6'h25;
	localparam logic [5:0] ADDR_STILL_DUR = 6'h26;
	localparam logic [5:0] ADDR_AXIS_CTL = 6'h27;
	localparam logic [5:0] ADDR_RATE_PWR = 6'h2C;
	localparam logic [5:0] ADDR_PWR_CTL = 6'h2D;
	localparam logic [5:0] ADDR_DATA_FIRST = 6'h32;
	localparam logic [5:0] ADDR_DATA_LAST = 6'h37;
	// Reset values, write masks and the soft reset key
	localparam logic [7:0] RESET_CMD_KEY = 8'h52;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] RATE_PWR_RESET = 8'h0A;
	localparam logic [7:0] RATE_PWR_MASK = 8'h1F;
	localparam logic [7:0] PWR_CTL_MASK = 8'h7F;
	// Field positions in motion_axis_control
	localparam int MOT_COUPLING_BIT = 7;
	localparam int MOT_AXIS_X_BIT = 6;
	localparam int STILL_COUPLING_BIT = 3;
	localparam int STILL_AXIS_X_BIT = 2;
	// Field positions in rate_and_power_select and power_control
	localparam int RATE_LSB = 0;
	localparam int LOW_POWER_BIT = 4;
	localparam int I2C_OFF_BIT = 6;
	localparam int CHAIN_BIT = 5;
	localparam int AUTO_SLEEP_BIT = 4;
	localparam int MEASURE_BIT = 3;
	localparam int SLEEP_BIT = 2;
	localparam int WAKE_LSB = 0;
	// Scaling at 1024 counts per g: 3.9 mg is 4 counts, 15.625 mg is 16
	localparam int OFFSET_SHIFT = 2;
	localparam int THRESH_SHIFT = 4;
	// Timing
	localparam longint CLK_HZ = 125000000;
	localparam longint STILL_STEP_S = 1;
	localparam longint STILL_STEP_CYCLES = STILL_STEP_S * CLK_HZ;
	localparam longint INIT_TIME_NS = 800;
	localparam int INIT_CYCLES = int'((INIT_TIME_NS * CLK_HZ
		+ 64'd999999999) / 64'd1000000000);
	// Chaining state machine
	typedef enum logic [2:0] {
		ST_FREE = 3'b001,
		ST_SEEK_STILL = 3'b010,
		ST_SEEK_MOTION = 3'b100
	} mdc_chain_t;
endpackage

// ### rtl/mdc_top.sv
// Motion detect configuration: serial registers, offsets, detection
// Contract
// R01 - Writing 0x52 to reset_command starts the soft reset.
// R02 - Soft reset restarts initialisation and restores configuration defaults.
// R03 - Offsets are signed 8-bit, 3.9 mg per count.
// R04 - Offset is added to each axis before storing output data.
// R05 - Motion threshold unsigned 8-bit, 15.625 mg per count, against magnitude.
// R06 - Stillness threshold unsigned 8-bit, 15.625 mg per count.
// R07 - Host avoids zero thresholds with the matching interrupt enabled.
// R08 - Stillness declared after staying below threshold for duration seconds.
// R09 - Stillness uses output samples; at least one sample needed first.
// R10 - Zero duration declares stillness as soon as output falls below.
// R11 - Coupling bit 0 compares magnitude directly, 1 is ac coupled.
// R12 - Ac motion latches a reference at start, compares differences.
// R13 - Ac stillness refreshes reference whenever threshold is exceeded.
// R14 - Axis enable bits include axes; no axis disables the function.
// R15 - Motion fires when any participating axis exceeds threshold.
// R16 - Stillness needs every participating axis below for the duration.
// R17 - Low power bit selects reduced power, noisier operation.
// R18 - Rate field defaults to 0x0A, the 100 Hz rate.
// R19 - Samples are discarded when the host link cannot keep up.
// R20 - With two-wire disabled, serial traffic never makes a start condition.
// R21 - Chained: motion waits for stillness, then stillness resumes.
// R22 - Unchained: motion and stillness run concurrently and independently.
// R23 - Host writes standby then measure separately when clearing chaining.
// R24 - Duration counter runs on the timebase, cleared when an axis rises.
module mdc_top #(
	parameter longint STEP_CYCLES = mdc_pkg::STILL_STEP_CYCLES,
	// Arbitrary neutral value
	parameter logic [7:0] SERIAL_CODE = 8'h5A
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Serial port pins, four-wire mode; sclk doubles as two-wire clock
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	output logic i2c_start,
	// Converter samples, same clock domain
	input wire logic sample_stb,
	input wire logic signed [15:0] raw_x,
	input wire logic signed [15:0] raw_y,
	input wire logic signed [15:0] raw_z,
	// Results
	output logic signed [15:0] out_x,
	output logic signed [15:0] out_y,
	output logic signed [15:0] out_z,
	output logic motion_evt,
	output logic stillness_evt,
	output logic init_busy,
	// Converter and power controls
	output logic [3:0] rate_sel,
	output logic low_power,
	output logic measure,
	output logic sleep,
	output logic auto_sleep,
	output logic [1:0] wake_rate
);
	if (STEP_CYCLES < 2 || STEP_CYCLES > 64'hFFFF_FFFF) begin : g_bad_step
		$error("STEP_CYCLES out of range");
	end

	// Configuration registers
	logic signed [7:0] offset_x_axis;
	logic signed [7:0] offset_y_axis;
	logic signed [7:0] offset_z_axis;
	logic [7:0] motion_threshold;
	logic [7:0] stillness_threshold;
	logic [7:0] stillness_duration;
	logic [7:0] motion_axis_control;
	logic [7:0] rate_and_power_select;
	logic [7:0] power_control;

	// Pin synchronisers: stage one feeds stage two only
	logic sclk_a, sclk_b, sclk_c, cs_a, cs_b, cs_c, sdi_a, sdi_b, sdi_c;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{sclk_a, sclk_b, sclk_c} <= 3'b111;
			{cs_a, cs_b, cs_c} <= 3'b111;
			{sdi_a, sdi_b, sdi_c} <= 3'b111;
		end else begin
			{sclk_a, sclk_b, sclk_c} <= {sclk, sclk_a, sclk_b};
			{cs_a, cs_b, cs_c} <= {cs_n, cs_a, cs_b};
			{sdi_a, sdi_b, sdi_c} <= {sdi, sdi_a, sdi_b};
		end
	end
	logic sel;
	logic sclk_rise;
	logic sclk_fall;
	assign sel = !cs_b;
	assign sclk_rise = sel && sclk_b && !sclk_c;
	assign sclk_fall = sel && !sclk_b && sclk_c;

	// Serial port byte engine
	logic [2:0] bit_cnt;
	logic first_byte;
	logic cmd_rd;
	logic cmd_mb;
	logic [5:0] addr;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [7:0] next_byte;
	logic byte_done;
	logic wr_en;
	logic [7:0] rd_data;
	logic [5:0] rd_addr;

	assign next_byte = {shift_in[6:0], sdi_b};
	assign byte_done = sclk_rise && (bit_cnt == 3'd7);
	assign wr_en = byte_done && !first_byte && !cmd_rd;
	assign rd_addr = first_byte ? next_byte[5:0]
		: (cmd_mb ? addr + 6'd1 : addr);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			bit_cnt <= 3'd0;
			first_byte <= 1'b1;
			cmd_rd <= 1'b0;
			cmd_mb <= 1'b0;
			addr <= 6'd0;
			shift_in <= 8'h00;
		end else if (!sel) begin
			bit_cnt <= 3'd0;
			first_byte <= 1'b1;
		end else if (sclk_rise) begin
			shift_in <= next_byte;
			bit_cnt <= bit_cnt + 3'd1;
			if (bit_cnt == 3'd7) begin
				first_byte <= 1'b0;
				addr <= rd_addr;
				if (first_byte) begin
					cmd_rd <= next_byte[7];
					cmd_mb <= next_byte[6];
				end
			end
		end
	end

	// Shift out on falling edges, mode 3
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_out <= 8'h00;
			sdo <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= sel && !first_byte && cmd_rd;
			if (byte_done && (first_byte ? next_byte[7] : cmd_rd)) begin
				shift_out <= rd_data;
			end else if (sclk_fall) begin
				sdo <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end

	// Two-wire start: data falls while clock high and chip select idle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			i2c_start <= 1'b0;
		end else begin
			i2c_start <= !power_control[mdc_pkg::I2C_OFF_BIT] && cs_b
				&& sclk_b && sclk_c && !sdi_b && sdi_c; // see R20
		end
	end

	// Register read mux
	always_comb begin
		case (rd_addr)
			mdc_pkg::ADDR_SERIAL: rd_data = SERIAL_CODE;
			mdc_pkg::ADDR_OFS_X: rd_data = offset_x_axis;
			mdc_pkg::ADDR_OFS_Y: rd_data = offset_y_axis;
			mdc_pkg::ADDR_OFS_Z: rd_data = offset_z_axis;
			mdc_pkg::ADDR_MOT_THR: rd_data = motion_threshold;
			mdc_pkg::ADDR_STILL_THR: rd_data = stillness_threshold;
			mdc_pkg::ADDR_STILL_DUR: rd_data = stillness_duration;
			mdc_pkg::ADDR_AXIS_CTL: rd_data = motion_axis_control;
			mdc_pkg::ADDR_RATE_PWR: rd_data = rate_and_power_select;
			mdc_pkg::ADDR_PWR_CTL: rd_data = power_control;
			mdc_pkg::ADDR_DATA_FIRST: rd_data = out_x[7:0];
			mdc_pkg::ADDR_DATA_FIRST + 6'd1: rd_data = out_x[15:8];
			mdc_pkg::ADDR_DATA_FIRST + 6'd2: rd_data = out_y[7:0];
			mdc_pkg::ADDR_DATA_FIRST + 6'd3: rd_data = out_y[15:8];
			mdc_pkg::ADDR_DATA_FIRST + 6'd4: rd_data = out_z[7:0];
			mdc_pkg::ADDR_DATA_LAST: rd_data = out_z[15:8];
			default: rd_data = 8'h00;
		endcase
	end

	// Soft reset and initialisation timer
	logic soft_rst;
	logic [7:0] init_cnt;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= wr_en && (addr == mdc_pkg::ADDR_RESET_CMD)
				&& (next_byte == mdc_pkg::RESET_CMD_KEY); // see R01
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			init_cnt <= 8'(mdc_pkg::INIT_CYCLES);
			init_busy <= 1'b1;
		end else if (soft_rst) begin
			init_cnt <= 8'(mdc_pkg::INIT_CYCLES); // see R02
			init_busy <= 1'b1;
		end else begin
			init_busy <= init_cnt > 8'd1;
			if (init_cnt != 8'd0) begin
				init_cnt <= init_cnt - 8'd1;
			end
		end
	end

	// Configuration writes; soft reset restores defaults
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			offset_x_axis <= mdc_pkg::CFG_RESET;
			offset_y_axis <= mdc_pkg::CFG_RESET;
			offset_z_axis <= mdc_pkg::CFG_RESET;
			motion_threshold <= mdc_pkg::CFG_RESET;
			stillness_threshold <= mdc_pkg::CFG_RESET;
			stillness_duration <= mdc_pkg::CFG_RESET;
			motion_axis_control <= mdc_pkg::CFG_RESET;
			rate_and_power_select <= mdc_pkg::RATE_PWR_RESET; // see R18
			power_control <= mdc_pkg::CFG_RESET;
		end else if (soft_rst) begin
			offset_x_axis <= mdc_pkg::CFG_RESET; // see R02
			offset_y_axis <= mdc_pkg::CFG_RESET;
			offset_z_axis <= mdc_pkg::CFG_RESET;
			motion_threshold <= mdc_pkg::CFG_RESET;
			stillness_threshold <= mdc_pkg::CFG_RESET;
			stillness_duration <= mdc_pkg::CFG_RESET;
			motion_axis_control <= mdc_pkg::CFG_RESET;
			rate_and_power_select <= mdc_pkg::RATE_PWR_RESET;
			power_control <= mdc_pkg::CFG_RESET;
		end else if (wr_en) begin
			case (addr)
				mdc_pkg::ADDR_OFS_X: offset_x_axis <= next_byte;
				mdc_pkg::ADDR_OFS_Y: offset_y_axis <= next_byte;
				mdc_pkg::ADDR_OFS_Z: offset_z_axis <= next_byte;
				mdc_pkg::ADDR_MOT_THR: motion_threshold <= next_byte;
				mdc_pkg::ADDR_STILL_THR: stillness_threshold <= next_byte;
				mdc_pkg::ADDR_STILL_DUR: stillness_duration <= next_byte;
				mdc_pkg::ADDR_AXIS_CTL: motion_axis_control <= next_byte;
				mdc_pkg::ADDR_RATE_PWR: begin
					rate_and_power_select <= next_byte & mdc_pkg::RATE_PWR_MASK;
				end
				mdc_pkg::ADDR_PWR_CTL: begin
					power_control <= next_byte & mdc_pkg::PWR_CTL_MASK;
				end
				default: ;
			endcase
		end
	end

	// Converter and power controls follow the registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rate_sel <= 4'h0;
			low_power <= 1'b0;
			measure <= 1'b0;
			sleep <= 1'b0;
			auto_sleep <= 1'b0;
			wake_rate <= 2'b00;
		end else begin
			rate_sel <= rate_and_power_select[mdc_pkg::RATE_LSB +: 4];
			low_power <= rate_and_power_select[mdc_pkg::LOW_POWER_BIT]; // see R17
			measure <= power_control[mdc_pkg::MEASURE_BIT];
			sleep <= power_control[mdc_pkg::SLEEP_BIT];
			auto_sleep <= power_control[mdc_pkg::AUTO_SLEEP_BIT];
			wake_rate <= power_control[mdc_pkg::WAKE_LSB +: 2];
		end
	end

	// Offset correction; samples dropped while the host holds the port
	logic take;
	logic have_sample;
	assign take = sample_stb && !init_busy && !sel; // see R19
	logic signed [15:0] next_out [3];
	assign next_out[0] = raw_x
		+ (16'(offset_x_axis) <<< mdc_pkg::OFFSET_SHIFT); // see R03 R04
	assign next_out[1] = raw_y
		+ (16'(offset_y_axis) <<< mdc_pkg::OFFSET_SHIFT);
	assign next_out[2] = raw_z
		+ (16'(offset_z_axis) <<< mdc_pkg::OFFSET_SHIFT);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_x <= 16'sh0000;
			out_y <= 16'sh0000;
			out_z <= 16'sh0000;
			have_sample <= 1'b0;
		end else if (soft_rst) begin
			have_sample <= 1'b0;
		end else if (take) begin
			out_x <= next_out[0]; // see R04
			out_y <= next_out[1];
			out_z <= next_out[2];
			have_sample <= 1'b1;
		end
	end

	// Axis comparators: motion on raw data, stillness on output data
	logic [2:0] mot_axes, still_axes, hit, below;
	logic mot_en, still_en, mot_run, still_run, mot_run_q, judge;
	logic signed [15:0] raw_v [3];
	assign raw_v = '{raw_x, raw_y, raw_z};
	assign mot_axes = motion_axis_control[mdc_pkg::MOT_AXIS_X_BIT -: 3];
	assign still_axes = motion_axis_control[mdc_pkg::STILL_AXIS_X_BIT -: 3];

	mdc_axis_if ax_if[3] ();
	for (genvar i = 0; i < 3; i++) begin : g_axis
		assign ax_if[i].sample_stb = take;
		assign ax_if[i].act_arm = mot_run && !mot_run_q;
		// Stillness judges the value being stored, so it is not a sample late
		assign ax_if[i].act_sample = raw_v[i];
		assign ax_if[i].inact_sample = next_out[i]; // see R09
		assign ax_if[i].act_thr = motion_threshold;
		assign ax_if[i].inact_thr = stillness_threshold;
		assign ax_if[i].act_ac = motion_axis_control[mdc_pkg::MOT_COUPLING_BIT];
		assign ax_if[i].inact_ac =
			motion_axis_control[mdc_pkg::STILL_COUPLING_BIT];
		assign hit[2 - i] = ax_if[i].act_hit;
		assign below[2 - i] = ax_if[i].inact_below;
		mdc_axis_det u_det (
			.clk_sys(clk_sys),
			.rst(rst),
			.bus(ax_if[i])
		);
	end

	// Chaining of motion and stillness
	mdc_pkg::mdc_chain_t chain, next_chain;
	assign mot_en = |mot_axes && measure; // see R14
	assign still_en = |still_axes && measure;
	always_comb begin
		next_chain = chain;
		case (chain)
			mdc_pkg::ST_FREE: begin
				if (power_control[mdc_pkg::CHAIN_BIT]) begin
					next_chain = mdc_pkg::ST_SEEK_STILL;
				end
			end
			mdc_pkg::ST_SEEK_STILL: begin
				if (!power_control[mdc_pkg::CHAIN_BIT]) begin
					next_chain = mdc_pkg::ST_FREE; // see R22
				end else if (stillness_evt) begin
					next_chain = mdc_pkg::ST_SEEK_MOTION; // see R21
				end
			end
			mdc_pkg::ST_SEEK_MOTION: begin
				if (!power_control[mdc_pkg::CHAIN_BIT]) begin
					next_chain = mdc_pkg::ST_FREE;
				end else if (motion_evt) begin
					next_chain = mdc_pkg::ST_SEEK_STILL; // see R21
				end
			end
			default: next_chain = mdc_pkg::ST_FREE;
		endcase
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chain <= mdc_pkg::ST_FREE;
		end else begin
			chain <= next_chain;
		end
	end

	// Chaining only bites with both functions enabled
	logic chained;
	assign chained = chain != mdc_pkg::ST_FREE && mot_en && still_en;
	assign mot_run = mot_en && (!chained || chain == mdc_pkg::ST_SEEK_MOTION);
	assign still_run = still_en
		&& (!chained || chain == mdc_pkg::ST_SEEK_STILL);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mot_run_q <= 1'b0;
			judge <= 1'b0;
		end else begin
			mot_run_q <= mot_run;
			judge <= take;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			motion_evt <= 1'b0;
		end else begin
			motion_evt <= judge && mot_run && mot_run_q
				&& |(hit & mot_axes); // see R15
		end
	end

	// Stillness duration in one-second steps of the timebase
	logic all_below, declared;
	logic [31:0] step_cnt;
	logic [7:0] still_secs;
	assign all_below = &(below | ~still_axes); // see R16
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			step_cnt <= 32'h0000_0000;
			still_secs <= 8'h00;
			declared <= 1'b0;
			stillness_evt <= 1'b0;
		end else begin
			stillness_evt <= 1'b0;
			if (!still_run || soft_rst || (judge && !all_below)) begin
				step_cnt <= 32'h0000_0000; // see R24
				still_secs <= 8'h00;
				declared <= 1'b0;
			end else if (have_sample) begin // see R09
				if (step_cnt == 32'(STEP_CYCLES - 1)) begin
					step_cnt <= 32'h0000_0000;
					if (still_secs != 8'hFF) begin
						still_secs <= still_secs + 8'd1;
					end
				end else begin
					step_cnt <= step_cnt + 32'd1;
				end
				if (judge && !declared && all_below
					&& still_secs >= stillness_duration) begin // see R08 R10
					declared <= 1'b1;
					stillness_evt <= 1'b1;
				end
			end
		end
	end
endmodule // mdc_top

// ### tb/mdc_host_model.sv
// Host side model: four-wire serial master in clock mode 3
module mdc_host_model (
	// Serial pins
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		sdi = 1'b1;
	end
	// One command byte plus one data byte; clock parks high between frames
	task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#80 sclk = 1'b0;
			sdi = tx[i];
			#80 sclk = 1'b1;
			rx = {rx[6:0], (sdo_oe === 1'b1) ? sdo : 1'bx};
		end
		#80 cs_n = 1'b1;
		// Released data line must not keep showing the last bit
		sdi = ~sdi;
		#240;
	endtask
	// Data falls while the clock is high: a two-wire start
	task automatic start_cond();
		sdi = 1'b1;
		#80 sdi = 1'b0;
		#160 sdi = 1'b1;
		#160;
	endtask
endmodule // mdc_host_model

// ### tb/mdc_top_bench.sv
// Self-checking bench for the motion detect block
module mdc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, sclk, cs_n, sdi, sdo, sdo_oe, i2c_start;
	logic sample_stb, motion_evt, stillness_evt, init_busy;
	logic signed [15:0] raw_x, raw_y, raw_z, out_x, out_y, out_z;
	logic [3:0] rate_sel;
	logic low_power, measure, sleep, auto_sleep;
	logic [1:0] wake_rate;
	logic [7:0] rd_val;
	int num_errors = 0;
	int check_count = 0;
	int n_mot = 0, n_still = 0, n_st = 0, em = 0, es = 0;
	int cycles = 0, base;
	// Arbitrary serial code for the bench
	localparam logic [7:0] SER = 8'h3C;

	mdc_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe));
	mdc_top #(.STEP_CYCLES(50), .SERIAL_CODE(SER)) i_dut (
		.clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .i2c_start(i2c_start),
		.sample_stb(sample_stb), .raw_x(raw_x), .raw_y(raw_y),
		.raw_z(raw_z), .out_x(out_x), .out_y(out_y), .out_z(out_z),
		.motion_evt(motion_evt), .stillness_evt(stillness_evt),
		.init_busy(init_busy), .rate_sel(rate_sel),
		.low_power(low_power), .measure(measure), .sleep(sleep),
		.auto_sleep(auto_sleep), .wake_rate(wake_rate));

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		n_mot += int'(motion_evt === 1'b1);
		n_still += int'(stillness_evt === 1'b1);
		n_st += int'(i2c_start === 1'b1);
		if (cycles == 40000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] rx;
		i_host.xfer({2'b00, a, d}, rx);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		i_host.xfer({2'b10, a, 8'h00}, rd_val);
		check(rd_val, exp);
	endtask
	// One sample, then compare the running event totals
	task automatic sx(input logic [15:0] x, y, z, input int dm, ds);
		@(posedge clk_sys);
		#1 raw_x = x;
		raw_y = y;
		raw_z = z;
		sample_stb = 1'b1;
		@(posedge clk_sys);
		#1 sample_stb = 1'b0;
		repeat (4) @(posedge clk_sys);
		em += dm;
		es += ds;
		check(16'(n_mot), 16'(em));
		check(16'(n_still), 16'(es));
	endtask

	initial begin
		rst = 1'b1;
		sample_stb = 1'b0;
		raw_x = 16'h0000;
		raw_y = 16'h0000;
		raw_z = 16'h0000;
		repeat (3) @(posedge clk_sys);
		#1 rst = 1'b0;
		check(16'(init_busy), 16'h0001);
		rd(6'h2C, 8'h0A);
		rd(6'h04, SER);
		wr(6'h04, 8'hFF);
		rd(6'h04, SER);
		rd(6'h10, 8'h00);
		// Reserved holes inside the range must swallow writes
		for (logic [5:0] a = 6'h1E; a <= 6'h27; a++) begin
			wr(a, {2'b10, a});
			rd(a, (a > 6'h20 && a < 6'h24) ? 8'h00 : {2'b10, a});
		end
		wr(6'h2C, 8'hFF);
		rd(6'h2C, 8'h1F);
		check(16'({low_power, rate_sel}), 16'h001F);
		wr(6'h18, 8'h51);
		rd(6'h24, 8'hA4);
		wr(6'h18, 8'h52);
		check(16'(init_busy), 16'h0001);
		sx(16'h0100, 16'h0000, 16'h0000, 0, 0);
		check(out_x, 16'h0000);
		repeat (120) @(posedge clk_sys);
		rd(6'h24, 8'h00);
		rd(6'h27, 8'h00);
		rd(6'h2C, 8'h0A);
		rd(6'h18, 8'h00);
		wr(6'h2D, 8'h17);
		check(16'({auto_sleep, sleep, measure, wake_rate}), 16'h001B);
		wr(6'h2D, 8'h08);
		wr(6'h24, 8'h02);
		wr(6'h25, 8'h01);
		wr(6'h27, 8'h20);
		sx(16'h03E8, 16'h0000, 16'h0000, 0, 0);
		sx(16'h0000, 16'hFFDF, 16'h0000, 1, 0);
		sx(16'h0000, 16'h0020, 16'h0000, 0, 0);
		wr(6'h27, 8'h03);
		sx(16'h01F4, 16'h0005, 16'h0005, 0, 1);
		wr(6'h26, 8'h01);
		sx(16'h0000, 16'h0014, 16'h0000, 0, 0);
		sx(16'h0000, 16'h0005, 16'h0000, 0, 0);
		repeat (60) @(posedge clk_sys);
		sx(16'h0000, 16'h0005, 16'h0000, 0, 1);
		wr(6'h27, 8'hC0);
		sx(16'h012C, 16'h0000, 16'h0000, 0, 0);
		sx(16'h0140, 16'h0000, 16'h0000, 0, 0);
		sx(16'h0154, 16'h0000, 16'h0000, 1, 0);
		wr(6'h27, 8'h44);
		wr(6'h26, 8'h00);
		wr(6'h2D, 8'h28);
		sx(16'h0064, 16'h0000, 16'h0000, 0, 0);
		sx(16'h0000, 16'h0000, 16'h0000, 0, 1);
		sx(16'h0064, 16'h0000, 16'h0000, 1, 0);
		sx(16'h0064, 16'h0000, 16'h0000, 0, 0);
		wr(6'h2D, 8'h00);
		wr(6'h2D, 8'h08);
		sx(16'h0064, 16'h0000, 16'h0000, 1, 0);
		sx(16'h0064, 16'h0000, 16'h0000, 1, 0);
		sx(16'h0000, 16'h0000, 16'h0000, 0, 1);
		wr(6'h27, 8'h00);
		wr(6'h1E, 8'h7F);
		wr(6'h1F, 8'h80);
		wr(6'h20, 8'h01);
		sx(16'h000A, 16'hFFFB, 16'h0000, 0, 0);
		check(out_x, 16'h0206);
		check(out_y, 16'hFDFB);
		check(out_z, 16'h0004);
		// A sample arriving mid-frame must be dropped
		fork
			rd(6'h32, 8'h06);
			begin
				repeat (10) @(posedge clk_sys);
				sx(16'h0000, 16'h0000, 16'h0000, 0, 0);
			end
		join
		check(out_x, 16'h0206);
		base = n_st;
		i_host.start_cond();
		check(16'(n_st), 16'(base + 1));
		wr(6'h2D, 8'h48);
		base = n_st;
		i_host.start_cond();
		check(16'(n_st), 16'(base));
		print_verdict();
	end
endmodule // mdc_top_bench

// ### tb/mdc_top_chk.sv
// Port level checks for the motion detect block
module mdc_top_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Pins and samples
	input wire logic cs_n,
	input wire logic sdo_oe,
	input wire logic sample_stb,
	// Results
	input wire logic signed [15:0] out_x,
	input wire logic signed [15:0] out_y,
	input wire logic signed [15:0] out_z,
	input wire logic motion_evt,
	input wire logic stillness_evt,
	input wire logic init_busy,
	input wire logic [3:0] rate_sel,
	input wire logic measure
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_init_holds: assert property (
		$fell(rst) |-> init_busy [*8])
		else $error("init_busy dropped early");
	a_rate_default: assert property (
		$fell(rst) |-> ##1 rate_sel == 4'hA)
		else $error("rate select not at default");
	a_soft_defaults: assert property (
		$rose(init_busy) |-> ##3 (rate_sel == 4'hA && !measure))
		else $error("soft reset left configuration");
	a_motion_cause: assert property (
		motion_evt |-> $past(sample_stb, 2) && !$past(init_busy, 2)
			&& measure)
		else $error("motion event without a taken sample");
	a_still_cause: assert property (
		stillness_evt |-> $past(sample_stb, 2) && !$past(init_busy, 2))
		else $error("stillness event without a taken sample");
	a_busy_discard: assert property (
		init_busy && $past(init_busy) && sample_stb
			|=> $stable(out_x) && $stable(out_y) && $stable(out_z))
		else $error("sample taken during init");
	a_cs_discard: assert property (
		!cs_n [*4] ##0 sample_stb
			|=> $stable(out_x) && $stable(out_y) && $stable(out_z))
		else $error("sample taken during serial access");
	a_sdo_release: assert property (
		cs_n [*8] |-> !sdo_oe)
		else $error("sdo driven while deselected");
	a_event_pulse: assert property (
		motion_evt || stillness_evt |=> !motion_evt && !stillness_evt)
		else $error("event longer than one cycle");
endmodule // mdc_top_chk

bind mdc_top mdc_top_chk i_chk (
	.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sdo_oe(sdo_oe),
	.sample_stb(sample_stb), .out_x(out_x), .out_y(out_y),
	.out_z(out_z), .motion_evt(motion_evt),
	.stillness_evt(stillness_evt), .init_busy(init_busy),
	.rate_sel(rate_sel), .measure(measure)
);
